// [src/gpt_pkg.sv]
package gpt_pkg;

    // ------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------
    localparam int          ADDR_W   = 4;
    localparam int          DATA_W   = 16;
    localparam logic [3:0]  REG_CTRL = 4'h0;
    localparam logic [3:0]  REG_PSC  = 4'h1;
    localparam logic [3:0]  REG_ARR  = 4'h2;
    localparam logic [3:0]  REG_CNT  = 4'h3;
    localparam logic [3:0]  REG_STAT = 4'h4;
    localparam logic [3:0]  REG_MASK = 4'h5;
    localparam logic [3:0]  REG_DMA  = 4'h6;
    localparam logic [3:0]  REG_CHMD = 4'h7;
    localparam logic [3:0]  REG_CCR0 = 4'h8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_EN     = 0;
    localparam int CTRL_DIR    = 1;
    localparam int CTRL_OPM    = 3;
    localparam int CTRL_DBG    = 4;
    localparam int CTRL_SLV    = 5;
    localparam int CTRL_HALL   = 7;
    localparam int STAT_UPD    = 0;
    localparam int STAT_CC     = 1;
    localparam int STAT_TRG    = 5;
    localparam int STAT_W      = 6;
    localparam int MAX_CH      = 4;
    localparam int CHMD_W      = 2;

    // ------------------------------------------------------------
    // Reset values and the unit increment
    // ------------------------------------------------------------
    localparam logic [15:0] ARR_RST = 16'hFFFF;
    localparam logic [15:0] PSC_RST = 16'h0000;
    localparam logic [15:0] ONE     = 16'h0001;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DIR_UP, DIR_DOWN, DIR_CENTER, DIR_RSVD} gpt_dir_t;
    typedef enum logic [1:0] {CH_CAPTURE, CH_COMPARE, CH_PWM, CH_ONEPULSE} gpt_chmode_t;
    typedef enum logic [1:0] {SLV_FREE, SLV_TRGRST, SLV_ENCODER, SLV_LSE} gpt_slave_t;

endpackage : gpt_pkg

// [src/gpt_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module gpt_channel (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire gpt_pkg::gpt_chmode_t mode,
    input  wire logic [15:0]          ccr,
    input  wire logic [15:0]          cnt,
    input  wire logic                 tick,
    input  wire logic                 pinIn,
    output logic                      pinOut,
    output logic [15:0]               capVal,
    output logic                      chEvent
);

    // ------------------------------------------------------------
    // Channel state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        prevIn;
        logic        out;
        logic [15:0] cap;
        logic        ev;
    } gpt_ch_state_t;

    gpt_ch_state_t s;
    gpt_ch_state_t next_s;

    // Capture latches the count on a rising input edge; the other modes drive the pin.
    always_comb begin
        next_s = s;
        next_s.prevIn = pinIn;
        next_s.ev = 1'b0;
        case (mode)
            gpt_pkg::CH_CAPTURE: begin
                if (pinIn && !s.prevIn) begin
                    next_s.cap = cnt;
                    next_s.ev = 1'b1;
                end
            end
            gpt_pkg::CH_COMPARE: begin
                if (tick && cnt == ccr) begin
                    next_s.out = !s.out;
                    next_s.ev = 1'b1;
                end
            end
            gpt_pkg::CH_PWM, gpt_pkg::CH_ONEPULSE: begin
                // One-pulse drives the pin exactly as PWM; only the CTRL one-pulse bit stops the counter.
                next_s.out = cnt < ccr;
                next_s.ev = tick && cnt == ccr;
            end
            default: next_s = s;
        endcase
    end

    // Single state register, frozen while the clock enable is low.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign pinOut  = s.out;
    assign capVal  = s.cap;
    assign chEvent = s.ev;

endmodule : gpt_channel
`default_nettype wire

// [src/gpt_timer.sv]
// Behaviour
// - 16-bit counter, auto-reload, up/down/centre counting.
// - Prescaler divides by any value 1..65536.
// - Full variant: four capture/compare/PWM/one-pulse channels.
// - Reduced variant: two channels, same 16-bit prescaler.
// - Only full variant raises DMA requests.
// - Trigger in and out over timer link.
// - Counter may freeze during debug halt.
// - Full variant decodes quadrature encoder, hall sensors.
// - Reduced variant may count low-speed external clock.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer #(
    parameter int NUM_CH  = 4,
    parameter bit HAS_DMA = 1'b1,
    parameter bit HAS_ENC = 1'b1,
    parameter bit HAS_LSE = 1'b0
) (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire logic [3:0]           regAddr,
    input  wire logic [15:0]          regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic [15:0]               regRdata,
    input  wire logic                 dbgHalt,
    input  wire logic                 lseClk,
    input  wire logic                 trgIn,
    output logic                      trgOut,
    input  wire logic                 encA,
    input  wire logic                 encB,
    input  wire logic [2:0]           hallIn,
    input  wire logic [NUM_CH-1:0]    chIn,
    output logic [NUM_CH-1:0]         chOut,
    output logic                      dmaReq,
    output logic                      irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                          enable;
        gpt_pkg::gpt_dir_t             dir;
        logic                          onePulse;
        logic                          dbgFreeze;
        gpt_pkg::gpt_slave_t           slave;
        logic                          hallEn;
        logic [15:0]                   pscVal;
        logic [15:0]                   psc;
        logic [15:0]                   arr;
        logic [15:0]                   cnt;
        logic                          countDown;
        logic                          stepped;
        logic [gpt_pkg::STAT_W-1:0]    stat;
        logic [gpt_pkg::STAT_W-1:0]    mask;
        logic                          dmaEn;
        logic [NUM_CH-1:0][1:0]        chMode;
        logic [NUM_CH-1:0][15:0]       ccr;
        logic                          lsePrev;
        logic                          trgPrev;
        logic                          encAPrev;
        logic                          encBPrev;
        logic [15:0]                   rdata;
        logic                          irq;
        logic                          trgOut;
        logic                          dmaReq;
    } gpt_state_t;

    gpt_state_t                 s;
    gpt_state_t                 next_s;
    logic                       run;
    logic                       srcTick;
    logic                       encStep;
    logic                       step;
    logic                       down;
    logic                       upd;
    logic                       trgEdge;
    logic [NUM_CH-1:0]          chEv;
    logic [NUM_CH-1:0]          chPin;
    logic [NUM_CH-1:0][15:0]    capVal;

    // True when the port addresses register idx with the given strobe.
    function automatic logic hit(input logic stb, input logic [3:0] a, input logic [3:0] idx);
        hit = stb && a == idx;
    endfunction : hit

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    // Hall sensors are combined by XOR onto channel 0, so a sensor edge captures only when it raises the XOR.
    always_comb begin
        chPin = chIn;
        if (HAS_ENC && s.hallEn) begin
            chPin[0] = ^hallIn;
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : gCh
        gpt_channel uCh (
            .core_clk (core_clk),
            .rstn     (rstn),
            .ce       (ce),
            .mode     (gpt_pkg::gpt_chmode_t'(s.chMode[i])),
            .ccr      (s.ccr[i]),
            .cnt      (s.cnt),
            .tick     (s.stepped),
            .pinIn    (chPin[i]),
            .pinOut   (chOut[i]),
            .capVal   (capVal[i]),
            .chEvent  (chEv[i])
        );
    end

    // ------------------------------------------------------------
    // Counting, registers and events
    // ------------------------------------------------------------
    // Register writes other than the count are applied first so that hardware flag sets win over a clear.
    always_comb begin
        next_s = s;
        next_s.rdata = '0;
        next_s.trgOut = 1'b0;
        next_s.dmaReq = 1'b0;
        next_s.stepped = 1'b0;
        next_s.lsePrev = lseClk;
        next_s.trgPrev = trgIn;
        next_s.encAPrev = encA;
        next_s.encBPrev = encB;
        upd = 1'b0;
        step = 1'b0;
        trgEdge = trgIn && !s.trgPrev;
        run = s.enable && !(s.dbgFreeze && dbgHalt);
        // Quadrature: A leading B counts up, B leading A counts down.
        encStep = HAS_ENC && s.slave == gpt_pkg::SLV_ENCODER
                  && ((encA ^ s.encAPrev) || (encB ^ s.encBPrev));
        case (s.slave)
            gpt_pkg::SLV_FREE, gpt_pkg::SLV_TRGRST: srcTick = 1'b1;
            gpt_pkg::SLV_LSE: srcTick = HAS_LSE && lseClk && !s.lsePrev;
            default: srcTick = 1'b0;
        endcase
        if (encStep) begin
            down = !(encA ^ s.encBPrev);
        end else begin
            down = s.dir == gpt_pkg::DIR_DOWN || (s.dir == gpt_pkg::DIR_CENTER && s.countDown);
        end

        // Register writes.
        if (hit(regWr, regAddr, gpt_pkg::REG_CTRL)) begin
            next_s.enable = regWdata[gpt_pkg::CTRL_EN];
            next_s.dir = gpt_pkg::gpt_dir_t'(regWdata[gpt_pkg::CTRL_DIR +: 2]);
            next_s.onePulse = regWdata[gpt_pkg::CTRL_OPM];
            next_s.dbgFreeze = regWdata[gpt_pkg::CTRL_DBG];
            next_s.slave = gpt_pkg::gpt_slave_t'(regWdata[gpt_pkg::CTRL_SLV +: 2]);
            next_s.hallEn = regWdata[gpt_pkg::CTRL_HALL];
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_PSC)) begin
            next_s.pscVal = regWdata;
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_ARR)) begin
            next_s.arr = regWdata;
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_STAT)) begin
            next_s.stat = s.stat & ~regWdata[gpt_pkg::STAT_W-1:0];
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_MASK)) begin
            next_s.mask = regWdata[gpt_pkg::STAT_W-1:0];
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_DMA)) begin
            next_s.dmaEn = HAS_DMA && regWdata[0];
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_CHMD)) begin
            next_s.chMode = regWdata[NUM_CH*gpt_pkg::CHMD_W-1:0];
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (hit(regWr, regAddr, gpt_pkg::REG_CCR0 + 4'(i))) begin
                next_s.ccr[i] = regWdata;
            end
        end

        // Prescaler: a divisor of pscVal+1 covers 1 through 65536.
        if (run && (srcTick || encStep)) begin
            if (s.psc >= s.pscVal) begin
                next_s.psc = '0;
                step = 1'b1;
            end else begin
                next_s.psc = s.psc + gpt_pkg::ONE;
            end
        end

        // Counter with reload at either end.
        if (step) begin
            next_s.stepped = 1'b1;
            if (!down) begin
                if (s.cnt >= s.arr) begin
                    upd = 1'b1;
                    if (s.dir == gpt_pkg::DIR_CENTER && !encStep) begin
                        next_s.cnt = s.arr - gpt_pkg::ONE;
                        next_s.countDown = 1'b1;
                    end else begin
                        next_s.cnt = '0;
                    end
                end else begin
                    next_s.cnt = s.cnt + gpt_pkg::ONE;
                end
            end else begin
                if (s.cnt == '0) begin
                    upd = 1'b1;
                    if (s.dir == gpt_pkg::DIR_CENTER && !encStep) begin
                        next_s.cnt = gpt_pkg::ONE;
                        next_s.countDown = 1'b0;
                    end else begin
                        next_s.cnt = s.arr;
                    end
                end else begin
                    next_s.cnt = s.cnt - gpt_pkg::ONE;
                end
            end
        end

        // A trigger edge restarts the count in reset mode; software writes override.
        if (trgEdge && s.slave == gpt_pkg::SLV_TRGRST) begin
            next_s.cnt = '0;
            next_s.psc = '0;
            next_s.countDown = 1'b0;
        end
        if (hit(regWr, regAddr, gpt_pkg::REG_CNT)) begin
            next_s.cnt = regWdata;
        end

        // Event flags set last so that they beat a same-cycle clear.
        if (upd) begin
            next_s.stat[gpt_pkg::STAT_UPD] = 1'b1;
            next_s.trgOut = 1'b1;
            next_s.dmaReq = HAS_DMA && s.dmaEn;
            if (s.onePulse) begin
                next_s.enable = 1'b0;
            end
        end
        if (trgEdge) begin
            next_s.stat[gpt_pkg::STAT_TRG] = 1'b1;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (chEv[i]) begin
                next_s.stat[gpt_pkg::STAT_CC + i] = 1'b1;
            end
        end
        next_s.irq = |(next_s.stat & next_s.mask);

        // Read data: one cycle after the strobe, zero otherwise.
        if (regRd) begin
            case (regAddr)
                gpt_pkg::REG_CTRL: begin
                    next_s.rdata[gpt_pkg::CTRL_EN] = s.enable;
                    next_s.rdata[gpt_pkg::CTRL_DIR +: 2] = s.dir;
                    next_s.rdata[gpt_pkg::CTRL_OPM] = s.onePulse;
                    next_s.rdata[gpt_pkg::CTRL_DBG] = s.dbgFreeze;
                    next_s.rdata[gpt_pkg::CTRL_SLV +: 2] = s.slave;
                    next_s.rdata[gpt_pkg::CTRL_HALL] = s.hallEn;
                end
                gpt_pkg::REG_PSC:  next_s.rdata = s.pscVal;
                gpt_pkg::REG_ARR:  next_s.rdata = s.arr;
                gpt_pkg::REG_CNT:  next_s.rdata = s.cnt;
                gpt_pkg::REG_STAT: next_s.rdata[gpt_pkg::STAT_W-1:0] = s.stat;
                gpt_pkg::REG_MASK: next_s.rdata[gpt_pkg::STAT_W-1:0] = s.mask;
                gpt_pkg::REG_DMA:  next_s.rdata[0] = s.dmaEn;
                gpt_pkg::REG_CHMD: next_s.rdata[NUM_CH*gpt_pkg::CHMD_W-1:0] = s.chMode;
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (regAddr == gpt_pkg::REG_CCR0 + 4'(i)) begin
                            // Capture channels show the latched count instead of ccr.
                            if (s.chMode[i] == gpt_pkg::CH_CAPTURE) begin
                                next_s.rdata = capVal[i];
                            end else begin
                                next_s.rdata = s.ccr[i];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Single state register; the clock enable freezes everything.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.arr <= gpt_pkg::ARR_RST;
            s.pscVal <= gpt_pkg::PSC_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign regRdata = s.rdata;
    assign trgOut   = s.trgOut;
    assign dmaReq   = s.dmaReq;
    assign irq      = s.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence sUpWrap;
        ce && step && !down && s.dir == gpt_pkg::DIR_UP && s.cnt >= s.arr && !regWr;
    endsequence
    sequence sReloaded;
        s.cnt == 16'h0000 && s.stat[gpt_pkg::STAT_UPD] && s.trgOut;
    endsequence
    sequence sDownWrap;
        ce && step && down && s.dir == gpt_pkg::DIR_DOWN && s.cnt == 16'h0000 && !regWr
        && !trgEdge;
    endsequence

    AST_UP_RELOAD: assert property (sUpWrap |=> sReloaded)
        else $error("Up count did not reload to zero with update flag.");
    AST_DOWN_RELOAD: assert property (sDownWrap |=> s.cnt == $past(s.arr))
        else $error("Down count did not reload from the auto-reload value.");
    AST_PSC_HOLD: assert property (ce && !regWr && s.psc < s.pscVal && !trgEdge
                                   |=> s.cnt == $past(s.cnt))
        else $error("Counter moved before prescaler terminal count.");
    AST_DBG_FREEZE: assert property (ce && s.dbgFreeze && dbgHalt && !regWr && !trgEdge
                                     |=> s.cnt == $past(s.cnt) && s.psc == $past(s.psc))
        else $error("Counter advanced during debug halt.");
    AST_DMA_CAUSE: assert property (dmaReq && $past(ce)
                                    |-> HAS_DMA && $past(upd) && $past(s.dmaEn))
        else $error("DMA request without an update or on a variant without DMA.");
    AST_TRG_RESET: assert property (ce && trgEdge && s.slave == gpt_pkg::SLV_TRGRST && !regWr
                                    |=> s.cnt == 16'h0000 && s.stat[gpt_pkg::STAT_TRG])
        else $error("Trigger edge did not restart the counter.");
    AST_CAP_FLAG: assert property (ce && chEv[0] |=> s.stat[gpt_pkg::STAT_CC])
        else $error("Channel event did not set its flag.");
    AST_IRQ_LEVEL: assert property (ce && s.stat[gpt_pkg::STAT_UPD] && s.mask[gpt_pkg::STAT_UPD]
                                    && !regWr ##1 !regWr |-> irq [*2])
        else $error("Masked-in update flag did not hold the interrupt high.");
    AST_ONE_PULSE: assert property (ce && upd && s.onePulse |=> !s.enable ##1 !s.enable)
        else $error("One-pulse mode kept counting after the update.");
    AST_LSE_GATE: assert property (ce && s.slave == gpt_pkg::SLV_LSE && !(HAS_LSE && lseClk
                                   && !s.lsePrev) && !regWr |=> $stable(s.psc))
        else $error("Counter advanced without a low-speed clock edge.");

endmodule : gpt_timer
`default_nettype wire

// [tb/gpt_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Pins, encoder and sensors on the timer's far side
// ------------------------------------------------------------
module gpt_pin_model (
    input  wire logic       core_clk,
    output logic            encA,
    output logic            encB,
    output logic            trgIn,
    output logic            lseClk,
    output logic [3:0]      chIn,
    output logic [2:0]      hallIn
);
    // All lines idle low; the hall sensors are left quiet.
    initial begin
        {encA, encB, trgIn, lseClk, chIn, hallIn} = '0;
    end

    // Gray steps: only one encoder line changes, so no step is ambiguous.
    task automatic quad(input int n, input bit fwd);
        repeat (n) begin
            repeat (4) @(posedge core_clk);
            if ((encA == encB) == fwd) encB <= ~encB;
            else encA <= ~encA;
        end
    endtask : quad

    // Slow clock edges, far apart so every edge is seen.
    task automatic low_speed_external_clock(input int n);
        repeat (n) begin
            repeat (5) @(posedge core_clk);
            lseClk <= 1'b1;
            repeat (5) @(posedge core_clk);
            lseClk <= 1'b0;
        end
    endtask : low_speed_external_clock

    // Pulses held three cycles so the edge detector cannot miss them.
    task automatic pulse(input bit trg);
        @(posedge core_clk);
        if (trg) trgIn <= 1'b1;
        else chIn[0] <= 1'b1;
        repeat (3) @(posedge core_clk);
        trgIn <= 1'b0;
        chIn[0] <= 1'b0;
    endtask : pulse

    // Sensor levels move one line at a time.
    task automatic hall(input logic [2:0] v);
        @(posedge core_clk);
        hallIn <= v;
    endtask : hall
endmodule : gpt_pin_model
`default_nettype wire

// [tb/general_purpose_timer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_test;
    typedef struct {logic [15:0] ctrl; logic [15:0] psc; logic [15:0] dma; logic [15:0] per;} gpt_row_t;
    logic        core_clk = 1'b0;
    logic        rstn     = 1'b0;
    logic [3:0]  regAddr  = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr    = 1'b0;
    logic        regRd    = 1'b0;
    logic        dbgHalt  = 1'b0;
    logic        ce       = 1'b1;
    logic [15:0] rdata, rdata2, rv, rv2;
    logic        trgOut, dmaReq, dmaReq2, irq, trgIn, lseClk, encA, encB;
    logic [3:0]  chIn, chOut;
    logic [1:0]  chOut2;
    logic [2:0]  hallIn;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          n;
    // Up, slower prescale, down, centre: centre updates at both ends.
    gpt_row_t    rows [4] = '{'{16'h0001, 16'h0000, 16'h0001, 16'h0004},
        '{16'h0001, 16'h0001, 16'h0000, 16'h0008}, '{16'h0003, 16'h0000, 16'h0000, 16'h0004},
        '{16'h0005, 16'h0000, 16'h0000, 16'h0003}};
    logic [3:0]  rstAddr [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hF};
    logic [15:0] rstVal [9] = '{16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};

    gpt_timer uut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(rdata), .dbgHalt(dbgHalt),
        .lseClk(lseClk), .trgIn(trgIn), .trgOut(trgOut), .encA(encA), .encB(encB),
        .hallIn(hallIn), .chIn(chIn), .chOut(chOut), .dmaReq(dmaReq), .irq(irq));
    // The reduced timer shares the register port, so it sees the same writes.
    gpt_timer #(.NUM_CH(2), .HAS_DMA(1'b0), .HAS_ENC(1'b0), .HAS_LSE(1'b1)) uut2 (
        .core_clk(core_clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(rdata2), .dbgHalt(dbgHalt), .lseClk(lseClk),
        .trgIn(trgIn), .trgOut(), .encA(encA), .encB(encB), .hallIn(hallIn),
        .chIn(chIn[1:0]), .chOut(chOut2), .dmaReq(dmaReq2), .irq());
    gpt_pin_model pins (.core_clk(core_clk), .encA(encA), .encB(encB), .trgIn(trgIn),
        .lseClk(lseClk), .chIn(chIn), .hallIn(hallIn));

    // ------------------------------------------------------------
    // Clock, bus tasks and report
    // ------------------------------------------------------------
    initial forever #5 core_clk = ~core_clk;

    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so take them there.
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        rv = rdata;
        rv2 = rdata2;
    endtask : rd

    task automatic waitUpd();
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (trgOut !== 1'b1 && n < 200);
    endtask : waitUpd

    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask : settle

    // A hang counts as a mismatch and ends the run in the report.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        wr(gpt_pkg::REG_ARR, 16'h0003);
        foreach (rows[i]) begin
            wr(gpt_pkg::REG_PSC, rows[i].psc);
            wr(gpt_pkg::REG_DMA, rows[i].dma);
            wr(gpt_pkg::REG_CTRL, rows[i].ctrl);
            waitUpd();
            waitUpd();
            chk("period", rows[i].per, 16'(n));
            chk("dmaReq", rows[i].dma, {15'h0, dmaReq});
            chk("dmaReq2", 16'h0, {15'h0, dmaReq2});
        end
        wr(gpt_pkg::REG_DMA, 16'h0001);
        rd(gpt_pkg::REG_DMA);
        chk("dma2", 16'h0000, rv2);
        // The stopped counter leaves its update flag pending.
        wr(gpt_pkg::REG_CTRL, 16'h0000);
        wr(gpt_pkg::REG_MASK, 16'h0000);
        rd(gpt_pkg::REG_STAT);
        chk("stat", 16'h0001, rv & 16'h0001);
        chk("irqMasked", 16'h0, {15'h0, irq});
        wr(gpt_pkg::REG_MASK, 16'h0001);
        settle();
        chk("irqOn", 16'h1, {15'h0, irq});
        wr(gpt_pkg::REG_STAT, 16'h0001);
        settle();
        chk("irqOff", 16'h0, {15'h0, irq});
        wr(gpt_pkg::REG_CTRL, 16'h0009);
        waitUpd();
        settle();
        rd(gpt_pkg::REG_CTRL);
        chk("onePulse", 16'h0008, rv);
        chk("irqEvent", 16'h1, {15'h0, irq});
        wr(gpt_pkg::REG_ARR, 16'hFFFF);
        wr(gpt_pkg::REG_CNT, 16'h0000);
        dbgHalt <= 1'b1;
        wr(gpt_pkg::REG_CTRL, 16'h0011);
        repeat (10) @(posedge core_clk);
        rd(gpt_pkg::REG_CNT);
        chk("frozen", 16'h0000, rv);
        dbgHalt <= 1'b0;
        repeat (10) @(posedge core_clk);
        rd(gpt_pkg::REG_CNT);
        chk("runs", 16'h0001, {15'h0, rv > 16'h0000});
        // Ten cycles with the clock enable low must not move the count.
        wr(gpt_pkg::REG_CNT, 16'h0000);
        ce <= 1'b0;
        repeat (10) @(posedge core_clk);
        ce <= 1'b1;
        rd(gpt_pkg::REG_CNT);
        chk("ceFreeze", 16'h0001, rv);
        wr(gpt_pkg::REG_CTRL, 16'h0000);
        wr(gpt_pkg::REG_CHMD, 16'h0000);
        wr(gpt_pkg::REG_CNT, 16'h1234);
        wr(gpt_pkg::REG_STAT, 16'h003F);
        pins.pulse(1'b0);
        settle();
        rd(gpt_pkg::REG_CCR0);
        chk("capture", 16'h1234, rv);
        rd(gpt_pkg::REG_STAT);
        chk("capFlag", 16'h0002, rv & 16'h0002);
        wr(gpt_pkg::REG_CTRL, 16'h0080);
        wr(gpt_pkg::REG_CNT, 16'h0042);
        pins.hall(3'h1);
        settle();
        rd(gpt_pkg::REG_CCR0);
        chk("hallCap", 16'h0042, rv);
        wr(gpt_pkg::REG_CTRL, 16'h0020);
        wr(gpt_pkg::REG_CNT, 16'h0055);
        pins.pulse(1'b1);
        settle();
        rd(gpt_pkg::REG_CNT);
        chk("trgReset", 16'h0000, rv);
        rd(gpt_pkg::REG_STAT);
        chk("trgFlag", 16'h0020, rv & 16'h0020);
        // Direction sense is open, so check distance and return only.
        wr(gpt_pkg::REG_CTRL, 16'h0041);
        wr(gpt_pkg::REG_CNT, 16'h0010);
        pins.quad(4, 1'b1);
        settle();
        rd(gpt_pkg::REG_CNT);
        chk("encFwd", 16'h1, {15'h0, rv == 16'h0014 || rv == 16'h000C});
        pins.quad(4, 1'b0);
        settle();
        rd(gpt_pkg::REG_CNT);
        chk("encBack", 16'h0010, rv);
        wr(gpt_pkg::REG_CTRL, 16'h0061);
        wr(gpt_pkg::REG_CNT, 16'h0000);
        pins.low_speed_external_clock(5);
        settle();
        rd(gpt_pkg::REG_CNT);
        chk("lseCount", 16'h0005, rv2);
        wr(gpt_pkg::REG_CHMD, 16'h0002);
        wr(gpt_pkg::REG_CCR0, 16'h0006);
        settle();
        chk("pwmOut", 16'h0003, {14'h0, chOut2[0], chOut[0]});
        // Reset in mid-run, then an unmapped write that must leave no trace.
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        chk("irqRst", 16'h0, {15'h0, irq});
        wr(4'hF, 16'hBEEF);
        foreach (rstAddr[i]) begin
            rd(rstAddr[i]);
            chk("resetVal", rstVal[i], rv);
        end
        summarize();
    end
endmodule : general_purpose_timer_test
`default_nettype wire
